// File: phyint_unit.sv
// phy interrupt unit: event latching, enables, test and polarity, apb slave
// assumes link events synchronous to clk and a single apb master
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module phyint_unit (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire phyint_pkg::phyint_evt_type evt,
  output var  logic                    int_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0]                 prdata_ff;
  logic [31:0]                 nxt_prdata;
  logic                        pready_ff;
  logic                        nxt_pready;
  logic                        pslverr_ff;
  logic                        nxt_pslverr;
  logic [15:0]                 test_ctrl_ff;
  logic [15:0]                 nxt_test_ctrl;
  logic [7:0]                  enable_ff;
  logic [7:0]                  nxt_enable;
  logic                        int_pin_ff;
  logic                        nxt_int_pin;
  phyint_pkg::phyint_prev_type prev_ff;
  phyint_pkg::phyint_prev_type nxt_prev;
  logic [7:0]                  flag_evt;
  logic [7:0]                  rd_clr;
  logic [7:0]                  pend;
  logic                        setup;
  logic                        access;
  logic                        hit_test;
  logic                        hit_stat;
  logic                        int_active;
  logic                        fc_cross;
  logic                        rx_cross;

  ////////////////////////////////////////////////////////////////////////////
  // event detection from levels and pulses
  always_comb begin
    fc_cross = (evt.false_carrier_count > phyint_pkg::HALF_WAY_COUNT) &&
               (prev_ff.false_carrier_count <= phyint_pkg::HALF_WAY_COUNT);
    rx_cross = (evt.rx_error_count > phyint_pkg::HALF_WAY_COUNT) &&
               (prev_ff.rx_error_count <= phyint_pkg::HALF_WAY_COUNT);
    flag_evt = '0;
    flag_evt[phyint_pkg::F_LINK_QUAL] = evt.link_up &&
      (evt.link_quality_good != prev_ff.link_quality_good);
    flag_evt[phyint_pkg::F_ENERGY]    = evt.energy_present != prev_ff.energy_present;
    flag_evt[phyint_pkg::F_LINK_STAT] = evt.link_up != prev_ff.link_up;
    flag_evt[phyint_pkg::F_WAKE]      = evt.wake_frame;
    flag_evt[phyint_pkg::F_DISCHARGE] = evt.static_discharge;
    flag_evt[phyint_pkg::F_TRAIN]     = evt.leader_follower_training_done;
    flag_evt[phyint_pkg::F_FALSE_CAR] = fc_cross;
    flag_evt[phyint_pkg::F_RX_ERR]    = rx_cross;
  end

  // previous levels for change detection
  always_comb begin
    nxt_prev.link_up             = evt.link_up;
    nxt_prev.link_quality_good   = evt.link_quality_good;
    nxt_prev.energy_present      = evt.energy_present;
    nxt_prev.false_carrier_count = evt.false_carrier_count;
    nxt_prev.rx_error_count      = evt.rx_error_count;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending flags; only bits already returned on the bus are cleared
  always_comb begin
    rd_clr = '0;
    if (access && !pwrite && hit_stat) begin
      rd_clr = prdata_ff[phyint_pkg::PEND_LSB +: phyint_pkg::FLAG_N];
    end
  end

  phyint_latch #(
    .N (phyint_pkg::FLAG_N)
  ) u_latch (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (flag_evt),
    .clr   (rd_clr),
    .pend  (pend)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access, data captured in the setup cycle
  always_comb begin
    setup    = psel && !penable;
    access   = psel && penable && pready_ff;
    hit_test = paddr == phyint_pkg::TEST_CTRL_ADDR;
    hit_stat = paddr == phyint_pkg::STATUS_ONE_ADDR;
  end

  always_comb begin
    nxt_pready    = setup;
    nxt_prdata    = prdata_ff;
    nxt_pslverr   = pslverr_ff;
    nxt_test_ctrl = test_ctrl_ff;
    nxt_enable    = enable_ff;
    if (setup) begin
      nxt_pslverr = !(hit_test || hit_stat);
      nxt_prdata  = '0;
      if (!pwrite && hit_test) begin
        nxt_prdata[phyint_pkg::REG_W-1:0] = test_ctrl_ff;
      end else if (!pwrite && hit_stat) begin
        nxt_prdata[phyint_pkg::REG_W-1:0] = {pend, enable_ff};
      end
    end
    // writes take effect at the access edge only
    if (access && pwrite && hit_test) begin
      nxt_test_ctrl = pwdata[phyint_pkg::REG_W-1:0];
    end
    if (access && pwrite && hit_stat) begin
      nxt_enable = pwdata[phyint_pkg::FLAG_N-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff    <= 1'b0;
      prdata_ff    <= '0;
      pslverr_ff   <= 1'b0;
      test_ctrl_ff <= phyint_pkg::TEST_CTRL_RST;
      enable_ff    <= phyint_pkg::ENABLE_RST;
    end else begin
      pready_ff    <= nxt_pready;
      prdata_ff    <= nxt_prdata;
      pslverr_ff   <= nxt_pslverr;
      test_ctrl_ff <= nxt_test_ctrl;
      enable_ff    <= nxt_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin: enabled pending flags or test force, then polarity
  always_comb begin
    int_active  = (|(pend & enable_ff)) || test_ctrl_ff[phyint_pkg::TEST_BIT];
    nxt_int_pin = int_active ^ test_ctrl_ff[phyint_pkg::POL_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_pin_ff <= phyint_pkg::INT_PIN_RST;
    end else begin
      int_pin_ff <= nxt_int_pin;
    end
  end

  // outputs straight from flip-flops
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign int_pin = int_pin_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  pin_active_a: assert property (
    int_active |=> (int_pin_ff == !$past(test_ctrl_ff[phyint_pkg::POL_BIT])))
    else $error("pin not at active level");

  pin_idle_a: assert property (
    !int_active |=> (int_pin_ff == $past(test_ctrl_ff[phyint_pkg::POL_BIT])))
    else $error("pin not idle without enabled flag");

  test_force_a: assert property (
    (test_ctrl_ff[phyint_pkg::TEST_BIT] && $stable(test_ctrl_ff[phyint_pkg::POL_BIT]))[*2]
      |-> (int_pin_ff == !test_ctrl_ff[phyint_pkg::POL_BIT]))
    else $error("test bit did not force interrupt");

  link_qual_a: assert property (
    (evt.link_up && $changed(evt.link_quality_good))
      |=> pend[phyint_pkg::F_LINK_QUAL])
    else $error("link quality change not latched");

  energy_chg_a: assert property (
    (evt.energy_present != $past(evt.energy_present)) |=> pend[phyint_pkg::F_ENERGY])
    else $error("energy change not latched");

  link_stat_a: assert property (
    $changed(evt.link_up) |=> pend[phyint_pkg::F_LINK_STAT])
    else $error("link status change not latched");

  wake_frame_a: assert property (
    evt.wake_frame |=> pend[phyint_pkg::F_WAKE])
    else $error("wake frame not latched");

  discharge_evt_a: assert property (
    evt.static_discharge |=> pend[phyint_pkg::F_DISCHARGE])
    else $error("discharge event not latched");

  train_done_a: assert property (
    evt.leader_follower_training_done |=> pend[phyint_pkg::F_TRAIN])
    else $error("training completion not latched");

  false_car_a: assert property (
    (evt.false_carrier_count > phyint_pkg::HALF_WAY_COUNT &&
     $past(evt.false_carrier_count) <= phyint_pkg::HALF_WAY_COUNT)
      |=> pend[phyint_pkg::F_FALSE_CAR])
    else $error("false carrier half way not latched");

  rx_err_a: assert property (
    (evt.rx_error_count > phyint_pkg::HALF_WAY_COUNT &&
     $past(evt.rx_error_count) <= phyint_pkg::HALF_WAY_COUNT)
      |=> pend[phyint_pkg::F_RX_ERR])
    else $error("receive error half way not latched");

  half_way_only_a: assert property (
    $rose(pend[phyint_pkg::F_FALSE_CAR]) |->
      ($past(evt.false_carrier_count) > phyint_pkg::HALF_WAY_COUNT))
    else $error("false carrier flag without crossing");

  enable_reset_a: assert property (
    $rose(rst_n) |-> (enable_ff == phyint_pkg::ENABLE_RST))
    else $error("enables not zero after reset");

  test_reset_a: assert property (
    $rose(rst_n) |-> (test_ctrl_ff == phyint_pkg::TEST_CTRL_RST))
    else $error("test control not at reset value");

  qual_link_down_a: assert property (
    (!evt.link_up && !pend[phyint_pkg::F_LINK_QUAL]) |=> !pend[phyint_pkg::F_LINK_QUAL])
    else $error("link quality latched while link down");

  rx_half_only_a: assert property (
    $rose(pend[phyint_pkg::F_RX_ERR]) |->
      ($past(evt.rx_error_count) > phyint_pkg::HALF_WAY_COUNT))
    else $error("receive error flag without crossing");

  ready_answer_a: assert property (
    (psel && !penable) |=> pready_ff)
    else $error("no ready after setup");

  ready_pulse_a: assert property (
    pready_ff |=> !pready_ff)
    else $error("ready held longer than one cycle");

  err_decode_a: assert property (
    (psel && !penable) |=> (pslverr_ff == !$past(hit_test || hit_stat)))
    else $error("error response wrong for address");

  enable_write_a: assert property (
    (access && pwrite && hit_stat) |=> (enable_ff == $past(pwdata[phyint_pkg::FLAG_N-1:0])))
    else $error("enable write not stored");

  test_write_a: assert property (
    (access && pwrite && hit_test) |=> (test_ctrl_ff == $past(pwdata[phyint_pkg::REG_W-1:0])))
    else $error("test control write not stored");

  unmapped_hold_a: assert property (
    (access && !hit_test && !hit_stat) |=> ($stable(enable_ff) && $stable(test_ctrl_ff)))
    else $error("unmapped write changed a register");

  status_read_a: assert property (
    (setup && !pwrite && hit_stat) |=> (prdata_ff[phyint_pkg::REG_W-1:0] == $past({pend, enable_ff})))
    else $error("status read data wrong");

  // per flag gating and read clearing
  for (genvar i = 0; i < phyint_pkg::FLAG_N; i++) begin : g_chk
    gate_bit_a: assert property (
      (pend[i] && enable_ff[i]) |=>
        (int_pin_ff == !$past(test_ctrl_ff[phyint_pkg::POL_BIT])))
      else $error("enabled flag did not raise pin");

    read_clear_a: assert property (
      (rd_clr[i] && !flag_evt[i]) |=> !pend[i])
      else $error("read did not clear flag");

    flag_hold_a: assert property (
      (pend[i] && !rd_clr[i]) |=> pend[i])
      else $error("flag dropped without read");

    pend_cause_a: assert property (
      $rose(pend[i]) |-> $past(flag_evt[i]))
      else $error("flag set without its event");
  end

endmodule

`default_nettype wire

// File: phyint_pkg.sv
// constants, field layout and carrier types of the phy interrupt unit
// assumes a 50 MHz clk and an apb master with 32-bit data and 12-bit address

package phyint_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map: printed offsets are indices, byte address is four times
  localparam int              ADDR_W          = 12;
  localparam logic [11:0]     TEST_CTRL_IDX   = 12'h011;
  localparam logic [11:0]     STATUS_ONE_IDX  = 12'h012;
  localparam logic [11:0]     TEST_CTRL_ADDR  = 12'(TEST_CTRL_IDX << 2);
  localparam logic [11:0]     STATUS_ONE_ADDR = 12'(STATUS_ONE_IDX << 2);

  ////////////////////////////////////////////////////////////////////////////
  // fields and reset values
  localparam int              REG_W           = 16;
  localparam int              FLAG_N          = 8;
  localparam int              PEND_LSB        = 8;
  localparam int              POL_BIT         = 3;
  localparam int              TEST_BIT        = 2;
  localparam logic [15:0]     TEST_CTRL_RST   = 16'h010B;
  localparam logic [7:0]      ENABLE_RST      = 8'h00;
  localparam logic            INT_PIN_RST     = 1'b1;

  // flag positions inside the pending and enable bytes
  localparam int              F_RX_ERR        = 0;
  localparam int              F_FALSE_CAR     = 1;
  localparam int              F_TRAIN         = 2;
  localparam int              F_DISCHARGE     = 3;
  localparam int              F_WAKE          = 4;
  localparam int              F_LINK_STAT     = 5;
  localparam int              F_ENERGY        = 6;
  localparam int              F_LINK_QUAL     = 7;

  // counter half way mark
  localparam int              CNT_W           = 8;
  localparam logic [7:0]      HALF_WAY_COUNT  = 8'h7F;

  ////////////////////////////////////////////////////////////////////////////
  // link side event inputs
  typedef struct packed {
    logic       link_up;
    logic       link_quality_good;
    logic       energy_present;
    logic       wake_frame;
    logic       static_discharge;
    logic       leader_follower_training_done;
    logic [7:0] false_carrier_count;
    logic [7:0] rx_error_count;
  } phyint_evt_type;

  // levels remembered for change detection
  typedef struct packed {
    logic       link_up;
    logic       link_quality_good;
    logic       energy_present;
    logic [7:0] false_carrier_count;
    logic [7:0] rx_error_count;
  } phyint_prev_type;

endpackage

// File: phyint_latch.sv
// latched_high_flag bank: one pending bit per event
// assumes events and clears are synchronous to clk
`timescale 1ns/10ps
`default_nettype none

module phyint_latch #(
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  output var  logic [N-1:0] pend
);

  // refuse a bank without flags at elaboration
  if (N < 1) begin : g_bad_n
    $error("phyint_latch needs at least one flag");
  end

  logic [N-1:0] pend_ff;
  logic [N-1:0] nxt_pend;

  ////////////////////////////////////////////////////////////////////////////
  // per flag: set beats clear, so an event in the read cycle survives
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_comb begin
      nxt_pend[i] = set[i] | (pend_ff[i] & ~clr[i]);
    end
  end

  // flag register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  assign pend = pend_ff;

endmodule

`default_nettype wire

// File: phyint_evt_src.sv
// link side event source standing in for the phy core beside the unit
// assumes the bench sets the wanted event levels and pulses just after a rising edge
`timescale 1ns/10ps
`default_nettype none

module phyint_evt_src (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire phyint_pkg::phyint_evt_type want,
  output var  phyint_pkg::phyint_evt_type evt
);
  // register the wanted events so they change only on the clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
    end else begin
      evt <= want;
    end
  end
endmodule

`default_nettype wire

// File: phy_interrupt_unit_tb_top.sv
// self-checking bench of the phy interrupt unit over apb
// assumes the event source model and the unit sources are compiled first
`timescale 1ns/10ps
`default_nettype none

module phy_interrupt_unit_tb_top;
  logic                       clk;
  logic                       rst_n;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [11:0]                paddr;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic                       int_pin;
  logic [31:0]                q;
  logic                       e;
  logic [7:0]                 b;
  int                         fail_count;
  int                         num_checks;
  phyint_pkg::phyint_evt_type want;
  phyint_pkg::phyint_evt_type evt;
  logic [15:0]                tv [4] = '{16'h0104, 16'h0100, 16'h010C, 16'h0108};
  logic [31:0]                pv [4] = '{32'h1, 32'h0, 32'h0, 32'h1};

  phyint_unit u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt(evt), .int_pin(int_pin));
  phyint_evt_src u_src (.clk(clk), .rst_n(rst_n), .want(want), .evt(evt));

  ////////////////////////////////////////////////////////////////////////////
  // clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // raise the event behind flag position i
  task automatic fire(input int i);
    case (i)
      0: begin
        want.rx_error_count <= 8'h00;
        tick(2);
        want.rx_error_count <= 8'h7F;
        tick(2);
        want.rx_error_count <= 8'h80;
      end
      1: begin
        want.false_carrier_count <= 8'h00;
        tick(2);
        want.false_carrier_count <= 8'h7F;
        tick(2);
        want.false_carrier_count <= 8'h80;
      end
      2: begin
        want.leader_follower_training_done <= 1'b1;
        tick(1);
        want.leader_follower_training_done <= 1'b0;
      end
      3: begin
        want.static_discharge <= 1'b1;
        tick(1);
        want.static_discharge <= 1'b0;
      end
      4: begin
        want.wake_frame <= 1'b1;
        tick(1);
        want.wake_frame <= 1'b0;
      end
      5: want.link_up <= ~want.link_up;
      6: want.energy_present <= ~want.energy_present;
      default: want.link_quality_good <= ~want.link_quality_good;
    endcase
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    want = '0;
    fail_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    tick(5);
    rst_n <= 1'b1;
    check(32'(int_pin), 32'h1);
    apb(1'b0, phyint_pkg::TEST_CTRL_ADDR, 32'h0, q, e);
    check(q, 32'h0000010B);
    apb(1'b0, phyint_pkg::STATUS_ONE_ADDR, 32'h0, q, e);
    check(q, 32'h0);
    $display("test reset done");
    // pass 0 enables only the firing flag, pass 1 all others
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        int i;
        i = (p == 0) ? k : 7 - k;
        b = (p == 0) ? 8'(8'h01 << i) : 8'(~(8'h01 << i));
        apb(1'b1, phyint_pkg::STATUS_ONE_ADDR, 32'(b), q, e);
        fire(i);
        tick(5);
        check(32'(int_pin), 32'(p));
        apb(1'b0, phyint_pkg::STATUS_ONE_ADDR, 32'h0, q, e);
        check(q, {16'h0000, 8'(8'h01 << i), b});
        apb(1'b0, phyint_pkg::STATUS_ONE_ADDR, 32'h0, q, e);
        check(q, {24'h000000, b});
        tick(2);
        check(32'(int_pin), 32'h1);
      end
      $display("test event pass %0d done", p);
    end
    // quality change with link down latches nothing
    fire(7);
    tick(4);
    check(32'(int_pin), 32'h1);
    apb(1'b0, phyint_pkg::STATUS_ONE_ADDR, 32'h0, q, e);
    check(q, 32'h000000FE);
    // polarity and forced test interrupt
    apb(1'b1, phyint_pkg::STATUS_ONE_ADDR, 32'h0, q, e);
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, phyint_pkg::TEST_CTRL_ADDR, 32'(tv[t]), q, e);
      tick(3);
      check(32'(int_pin), pv[t]);
      apb(1'b0, phyint_pkg::TEST_CTRL_ADDR, 32'h0, q, e);
      check(q, 32'(tv[t]));
    end
    $display("test polarity done");
    // unmapped address is refused and leaves registers alone
    apb(1'b1, 12'h04C, 32'h0000FFFF, q, e);
    check(32'(e), 32'h1);
    apb(1'b0, 12'h04C, 32'h0, q, e);
    check({q[31:1], e}, 32'h1);
    apb(1'b0, phyint_pkg::TEST_CTRL_ADDR, 32'h0, q, e);
    check(q, 32'h00000108);
    apb(1'b0, phyint_pkg::STATUS_ONE_ADDR, 32'h0, q, e);
    check(q, 32'h0);
    check(32'(e), 32'h0);
    $display("test unmapped done");
    print_verdict();
  end

  // watchdog against a hung transfer
  initial begin
    tick(20000);
    fail_count++;
    print_verdict();
  end
endmodule

`default_nettype wire
